// file: logic/cpw_pkg.sv
// Constants and types shared by the counter compare and PWM block
package cpw_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_SYS_ONE = 8'h08;
  localparam logic [7:0] ADDR_PRESC = 8'h0C;
  localparam logic [7:0] ADDR_DATA_LOW = 8'h10;
  localparam logic [7:0] ADDR_DATA_MID = 8'h14;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CTL1_UP_BIT = 3;
  localparam int CTL1_SEL_MSB = 2;
  localparam int CTL2_START_BIT = 3;
  localparam int CTL2_EVCNT_BIT = 2;
  localparam int CTL2_CMPEN_BIT = 1;
  localparam int CTL2_LOAD_BIT = 0;
  localparam int SYS1_FULL_BIT = 1;
  localparam int PRESC_PWM_BIT = 3;
  localparam int HIGH_LEN_LSB = 2;

  // ==========================================================
  // Values after reset
  localparam logic [9:0] COUNT_RESET = 10'h000;
  localparam logic [9:0] PRESET_RESET = 10'h000;
  localparam logic [5:0] SHADOW_RESET = 6'h00;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LEN_10 = 2'b00,
    LEN_8 = 2'b01,
    LEN_6 = 2'b10,
    LEN_4 = 2'b11
  } cpw_len_e;

  typedef struct packed {
    logic up;
    logic [2:0] clk_sel;
    logic start;
    logic evcnt;
    logic cmp_en;
    logic full_sel;
    logic pwm_route;
    cpw_len_e len;
  } cpw_ctrl_s;

  typedef struct packed {
    cpw_ctrl_s ctl;
    logic [9:0] count;
    logic [9:0] preset;
    logic [5:0] shadow;
    logic clk_prev;
    logic armed;
    logic pwm;
    logic pin;
    logic cmp_irq;
    logic roll_irq;
    logic ready;
    logic err;
    logic [3:0] rdata;
  } cpw_state_s;

  typedef struct packed {
    logic rollover;
    logic pwm_match;
    logic irq_match;
  } cpw_eval_s;

  localparam cpw_ctrl_s CTRL_RESET = '{up: 1'b0, clk_sel: CLKSEL_RESET, start: 1'b0,
    evcnt: 1'b0, cmp_en: 1'b0, full_sel: 1'b0, pwm_route: 1'b0, len: LEN_10};

endpackage

// file: logic/cpw_sync.sv
// Two flip-flop synchroniser for the selected counting clock
module cpw_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);

  typedef struct packed {
    logic meta;
    logic stable;
  } cpw_sync_s;

  cpw_sync_s s_q;
  cpw_sync_s s_d;

  always_comb begin
    s_d.meta = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule // cpw_sync

// file: logic/cpw_eval.sv
// Roll-over and compare evaluation for a freshly stepped counter value
module cpw_eval (
  // Counter and compare data
  input wire logic [9:0] value_i,
  input wire logic [9:0] preset_i,
  // Configuration
  input wire cpw_pkg::cpw_len_e len_i,
  input wire logic up_i,
  input wire logic full_i,
  input wire logic cmp_en_i,
  // Results
  output cpw_pkg::cpw_eval_s eval_o
);

  logic [9:0] mask;
  logic limited_eq;

  always_comb begin
    unique case (len_i)
      cpw_pkg::LEN_10: mask = 10'h3FF;
      cpw_pkg::LEN_8: mask = 10'h0FF;
      cpw_pkg::LEN_6: mask = 10'h03F;
      cpw_pkg::LEN_4: mask = 10'h00F;
    endcase
    limited_eq = ((value_i ^ preset_i) & mask) == 10'h000;
    eval_o.rollover = up_i ? ((value_i & mask) == mask) : ((value_i & mask) == 10'h000);
    eval_o.pwm_match = cmp_en_i & limited_eq;
    eval_o.irq_match = cmp_en_i & (full_i ? (value_i == preset_i) : limited_eq);
  end

endmodule // cpw_eval

// file: logic/cpw_counter_compare_pwm.sv
// Counter compare, PWM and setup logic behind an APB register slave
module cpw_counter_compare_pwm (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Selected counting clock, asynchronous
  input wire logic count_clk_i,
  // Clock source controls for the external selector
  output logic [2:0] clock_select_o,
  output logic event_count_enable_o,
  // Requests and PWM pin
  output logic compare_match_irq_o,
  output logic rollover_irq_o,
  output logic pwm_output_pin_o
);

  // ==========================================================
  // State
  cpw_pkg::cpw_state_s s_q;
  cpw_pkg::cpw_state_s s_d;
  cpw_pkg::cpw_eval_s ev;
  logic clk_sync;
  logic rise;
  logic fall;
  logic step;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [9:0] next_count;
  logic [9:0] load_val;
  // Length field sits just above the two top preset bits
  localparam int HIGH_LEN_MSB = cpw_pkg::HIGH_LEN_LSB + 1;

  cpw_sync u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i(count_clk_i),
    .sync_o(clk_sync)
  );

  cpw_eval u_eval (
    .value_i(next_count),
    .preset_i(s_q.preset),
    .len_i(s_q.ctl.len),
    .up_i(s_q.ctl.up),
    .full_i(s_q.ctl.full_sel),
    .cmp_en_i(s_q.ctl.cmp_en),
    .eval_o(ev)
  );

  // ==========================================================
  // Decode
  assign rise = clk_sync & ~s_q.clk_prev;
  assign fall = ~clk_sync & s_q.clk_prev;
  assign step = s_q.ctl.start & s_q.armed & rise;
  assign next_count = s_q.ctl.up ? s_q.count + 10'h001 : s_q.count - 10'h001;
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & s_q.ready;
  assign wr = access & pwrite_i & ~s_q.err;
  assign mapped = (paddr_i == cpw_pkg::ADDR_CTRL_ONE) | (paddr_i == cpw_pkg::ADDR_CTRL_TWO)
    | (paddr_i == cpw_pkg::ADDR_SYS_ONE) | (paddr_i == cpw_pkg::ADDR_PRESC)
    | (paddr_i == cpw_pkg::ADDR_DATA_LOW) | (paddr_i == cpw_pkg::ADDR_DATA_MID)
    | (paddr_i == cpw_pkg::ADDR_DATA_HIGH);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    load_val = s_q.preset;
    s_d.cmp_irq = 1'b0;
    s_d.roll_irq = 1'b0;
    s_d.clk_prev = clk_sync;

    // Without event counting a falling edge must be seen first
    if (!s_q.ctl.start) begin
      s_d.armed = 1'b0;
    end else if (s_q.ctl.evcnt || fall) begin
      s_d.armed = 1'b1;
    end

    if (step) begin
      s_d.count = next_count;
      s_d.roll_irq = ev.rollover;
      s_d.cmp_irq = ev.irq_match;
      if (s_q.ctl.cmp_en && ev.rollover) begin
        s_d.pwm = s_q.ctl.up;
      end
      if (ev.pwm_match) begin
        s_d.pwm = s_q.ctl.up ? 1'b0 : 1'b1;
      end
      // self stop in full compare with routing
      if (ev.irq_match && s_q.ctl.full_sel && s_q.ctl.pwm_route) begin
        s_d.ctl.start = 1'b0;
      end
    end

    // APB setup: prepare answer one cycle ahead
    if (setup) begin
      s_d.ready = 1'b1;
      s_d.err = ~mapped;
      s_d.rdata = 4'h0;
      unique case (paddr_i)
        cpw_pkg::ADDR_CTRL_ONE: s_d.rdata = {s_q.ctl.up, s_q.ctl.clk_sel};
        cpw_pkg::ADDR_CTRL_TWO: s_d.rdata = {s_q.ctl.start, s_q.ctl.evcnt, s_q.ctl.cmp_en, 1'b0};
        cpw_pkg::ADDR_SYS_ONE: s_d.rdata = {2'b00, s_q.ctl.full_sel, 1'b0};
        cpw_pkg::ADDR_PRESC: s_d.rdata = {s_q.ctl.pwm_route, 3'b000};
        cpw_pkg::ADDR_DATA_LOW: s_d.rdata = s_q.count[3:0];
        cpw_pkg::ADDR_DATA_MID: s_d.rdata = s_q.shadow[3:0];
        cpw_pkg::ADDR_DATA_HIGH: s_d.rdata = {s_q.ctl.len, s_q.shadow[5:4]};
        default: s_d.rdata = 4'h0;
      endcase
      if (!pwrite_i && paddr_i == cpw_pkg::ADDR_DATA_LOW) begin
        s_d.shadow = s_q.count[9:4];
      end
    end

    // APB access: writes take effect at completion
    if (access) begin
      s_d.ready = 1'b0;
      s_d.err = 1'b0;
    end
    if (wr) begin
      unique case (paddr_i)
        cpw_pkg::ADDR_CTRL_ONE: begin
          s_d.ctl.clk_sel = pwdata_i[cpw_pkg::CTL1_SEL_MSB:0];
          s_d.ctl.up = pwdata_i[cpw_pkg::CTL1_UP_BIT];
          if (pwdata_i[cpw_pkg::CTL1_UP_BIT] != s_q.ctl.up) begin
            s_d.count = ~s_d.count;
          end
        end
        cpw_pkg::ADDR_CTRL_TWO: begin
          s_d.ctl.start = pwdata_i[cpw_pkg::CTL2_START_BIT];
          s_d.ctl.evcnt = pwdata_i[cpw_pkg::CTL2_EVCNT_BIT];
          s_d.ctl.cmp_en = pwdata_i[cpw_pkg::CTL2_CMPEN_BIT];
          if (pwdata_i[cpw_pkg::CTL2_LOAD_BIT]) begin
            s_d.count = load_val;
            s_d.cmp_irq = 1'b0;
            s_d.roll_irq = 1'b0;
            s_d.ctl.cmp_en = 1'b0;
            if (load_val == 10'h000) begin
              s_d.ctl.start = 1'b0;
            end
          end
        end
        cpw_pkg::ADDR_SYS_ONE: s_d.ctl.full_sel = pwdata_i[cpw_pkg::SYS1_FULL_BIT];
        cpw_pkg::ADDR_PRESC: s_d.ctl.pwm_route = pwdata_i[cpw_pkg::PRESC_PWM_BIT];
        cpw_pkg::ADDR_DATA_LOW: s_d.preset[3:0] = pwdata_i[3:0];
        cpw_pkg::ADDR_DATA_MID: s_d.preset[7:4] = pwdata_i[3:0];
        cpw_pkg::ADDR_DATA_HIGH: begin
          s_d.preset[9:8] = pwdata_i[1:0];
          s_d.ctl.len = cpw_pkg::cpw_len_e'(pwdata_i[HIGH_LEN_MSB:cpw_pkg::HIGH_LEN_LSB]);
        end
        default: s_d.err = 1'b0;
      endcase
    end

    // start level forced while compare is off
    if (!s_d.ctl.cmp_en) begin
      s_d.pwm = ~s_d.ctl.up;
    end
    // route PWM level to the pin
    s_d.pin = s_d.ctl.pwm_route & s_d.pwm;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q.ctl <= cpw_pkg::CTRL_RESET;
      s_q.count <= cpw_pkg::COUNT_RESET;
      s_q.preset <= cpw_pkg::PRESET_RESET;
      s_q.shadow <= cpw_pkg::SHADOW_RESET;
      s_q.clk_prev <= 1'b0;
      s_q.armed <= 1'b0;
      s_q.pwm <= 1'b1;
      s_q.pin <= 1'b0;
      s_q.cmp_irq <= 1'b0;
      s_q.roll_irq <= 1'b0;
      s_q.ready <= 1'b0;
      s_q.err <= 1'b0;
      s_q.rdata <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign prdata_o = {28'h0000000, s_q.rdata};
  assign pready_o = s_q.ready;
  assign pslverr_o = s_q.err;
  assign clock_select_o = s_q.ctl.clk_sel;
  assign event_count_enable_o = s_q.ctl.evcnt;
  assign compare_match_irq_o = s_q.cmp_irq;
  assign rollover_irq_o = s_q.roll_irq;
  assign pwm_output_pin_o = s_q.pin;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  sequence load_write;
    wr && paddr_i == cpw_pkg::ADDR_CTRL_TWO && pwdata_i[cpw_pkg::CTL2_LOAD_BIT];
  endsequence

  sequence quiet_step;
    step && !wr;
  endsequence

  sequence up_step;
    quiet_step ##0 s_q.ctl.up;
  endsequence

  sequence down_step;
    quiet_step ##0 !s_q.ctl.up;
  endsequence

  chk_cmp_gated: assert property (compare_match_irq_o |-> $past(s_q.ctl.cmp_en))
    else $error("compare request without compare enable");
  chk_pwm_idle: assert property (!s_q.ctl.cmp_en |-> s_q.pwm == !s_q.ctl.up)
    else $error("PWM level not at start value");
  chk_load_copy: assert property (load_write |=> !s_q.ctl.cmp_en
    && s_q.count == $past(s_q.preset))
    else $error("preset transfer did not copy or clear enable");
  chk_load_stop: assert property (load_write ##0 s_q.preset == 10'h000 |=> !s_q.ctl.start)
    else $error("zero preset did not stop counter");
  chk_load_quiet: assert property (load_write |=> !compare_match_irq_o && !rollover_irq_o)
    else $error("request raised by preset transfer");
  chk_dir_invert: assert property (wr && !step && paddr_i == cpw_pkg::ADDR_CTRL_ONE
    && pwdata_i[cpw_pkg::CTL1_UP_BIT] != s_q.ctl.up |=> s_q.count == ~$past(s_q.count))
    else $error("direction change did not invert counter");
  chk_shadow_latch: assert property (setup && !pwrite_i && paddr_i == cpw_pkg::ADDR_DATA_LOW
    |=> s_q.shadow == $past(s_q.count[9:4]))
    else $error("shadow not latched on low read");
  chk_step_one: assert property (quiet_step |=> s_q.count == $past(next_count))
    else $error("counter did not step by one");
  chk_auto_stop: assert property (quiet_step ##0 ev.irq_match && s_q.ctl.full_sel
    && s_q.ctl.pwm_route |=> !s_q.ctl.start && compare_match_irq_o)
    else $error("counter did not stop after full compare");
  chk_pwm_up_roll: assert property (quiet_step ##0 s_q.ctl.up && s_q.ctl.cmp_en
    && ev.rollover && !ev.pwm_match |=> s_q.pwm)
    else $error("PWM not high after up roll-over");
  chk_pwm_up_match: assert property (up_step ##0 ev.pwm_match
    |=> !s_q.pwm)
    else $error("PWM not low after up compare match");
  chk_pwm_dn_roll: assert property (down_step ##0 s_q.ctl.cmp_en
    && ev.rollover && !ev.pwm_match |=> !s_q.pwm)
    else $error("PWM not low after down roll-over");
  chk_pwm_dn_match: assert property (down_step ##0 ev.pwm_match
    |=> s_q.pwm)
    else $error("PWM not high after down compare match");
  chk_pwm_len_only: assert property (up_step ##0 s_q.ctl.cmp_en
    && s_q.ctl.full_sel && s_q.ctl.len == cpw_pkg::LEN_4
    && next_count[3:0] == s_q.preset[3:0] |=> !s_q.pwm)
    else $error("PWM match did not use the selected length");
  chk_full_cmp: assert property (quiet_step ##0 s_q.ctl.cmp_en && s_q.ctl.full_sel
    && next_count != s_q.preset |=> !compare_match_irq_o)
    else $error("full-width compare matched on a partial value");
  chk_limited_cmp: assert property (quiet_step ##0 s_q.ctl.cmp_en && !s_q.ctl.full_sel
    && s_q.ctl.len == cpw_pkg::LEN_4 && next_count[3:0] == s_q.preset[3:0]
    |=> compare_match_irq_o)
    else $error("limited compare missed a low-bit match");
  chk_roll_down: assert property (down_step ##0 next_count == 10'h000
    |=> rollover_irq_o)
    else $error("no roll-over request at zero");
  chk_roll_up: assert property (up_step ##0 next_count == 10'h3FF
    |=> rollover_irq_o)
    else $error("no roll-over request at all ones");
  chk_roll_none: assert property (quiet_step ##0 next_count[3:0] != 4'h0
    && next_count[3:0] != 4'hF |=> !rollover_irq_o)
    else $error("roll-over request away from the range end");
  chk_req_on_step: assert property (!step |=> !compare_match_irq_o && !rollover_irq_o)
    else $error("request raised without a counter step");
  chk_count_hold: assert property (!step && !wr |=> s_q.count == $past(s_q.count))
    else $error("counter value changed without a step or write");
  chk_pin_route: assert property (pwm_output_pin_o == (s_q.ctl.pwm_route && s_q.pwm))
    else $error("PWM pin does not follow routed level");
  // Answer one cycle after setup
  chk_ready_next: assert property (setup |=> pready_o && pslverr_o == !$past(mapped))
    else $error("no single-cycle answer after setup");
  // Answer lasts one cycle
  chk_ready_once: assert property (pready_o && psel_i && penable_i |=> !pready_o)
    else $error("ready held past the access cycle");

endmodule // cpw_counter_compare_pwm

// file: test/tb.sv
// Self-checking testbench for the counter compare and PWM block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Design connections
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic count_clk_i = 1'b0;
  logic [2:0] clock_select_o;
  logic event_count_enable_o;
  logic compare_match_irq_o;
  logic rollover_irq_o;
  logic pwm_output_pin_o;
  int fails = 0;
  int total_checks = 0;
  int seed = 49864;
  int ncmp = 0;
  int nroll = 0;
  // Model state, plain integers
  int up, sel, start, ev, cmpen, full, route, len, preset, count, shadow, pwm, mcmp, mroll;
  cpw_counter_compare_pwm cpw_counter_compare_pwm_inst (.mclk_i, .reset_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .count_clk_i, .clock_select_o, .event_count_enable_o, .compare_match_irq_o,
    .rollover_irq_o, .pwm_output_pin_o);
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  // Requests are one-cycle pulses, so they are tallied as they pass
  always @(posedge mclk_i) begin
    if (compare_match_irq_o === 1'b1) ncmp++;
    if (rollover_irq_o === 1'b1) nroll++;
  end
  // ==========================================================
  // Reporting
  task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up;
  end
  // ==========================================================
  // Model of the register file and counter
  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    case (a)
      cpw_pkg::ADDR_CTRL_ONE: begin
        if (d[3] != up) count = ~count & 1023;
        up = d[3];
        sel = d[2:0];
      end
      cpw_pkg::ADDR_CTRL_TWO: begin
        start = d[3];
        ev = d[2];
        cmpen = d[1];
        if (d[0]) begin
          count = preset;
          cmpen = 0;
          if (preset == 0) start = 0;
        end
      end
      cpw_pkg::ADDR_SYS_ONE: full = d[1];
      cpw_pkg::ADDR_PRESC: route = d[3];
      cpw_pkg::ADDR_DATA_LOW: preset = (preset & 1008) | d[3:0];
      cpw_pkg::ADDR_DATA_MID: preset = (preset & 783) | (d[3:0] << 4);
      cpw_pkg::ADDR_DATA_HIGH: begin
        len = d[3:2];
        preset = (preset & 255) | (d[1:0] << 8);
      end
      default: ;
    endcase
    if (!cmpen) pwm = !up;
  endtask
  task automatic mstep;
    int m;
    int v;
    int roll;
    int pm;
    int im;
    if (!start) return;
    count = up ? (count + 1) & 1023 : (count + 1023) & 1023;
    m = 1023 >> (2 * len);
    v = count & m;
    roll = up ? v == m : v == 0;
    pm = v == (preset & m);
    im = cmpen && (full ? count == preset : pm);
    mroll += roll;
    mcmp += im;
    if (cmpen && roll) pwm = up;
    if (cmpen && pm) pwm = !up;
    if (full && route && im) start = 0;
  endtask
  // ==========================================================
  // APB master and count clock
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    mwr(a, d);
    chk("wr_err", a > 8'h18 || a[1:0] != 0, e);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    case (a)
      cpw_pkg::ADDR_CTRL_ONE: x = up * 8 + sel;
      cpw_pkg::ADDR_CTRL_TWO: x = start * 8 + ev * 4 + cmpen * 2;
      cpw_pkg::ADDR_SYS_ONE: x = full * 2;
      cpw_pkg::ADDR_PRESC: x = route * 8;
      cpw_pkg::ADDR_DATA_LOW: begin
        x = count & 15;
        shadow = count >> 4;
      end
      cpw_pkg::ADDR_DATA_MID: x = shadow & 15;
      cpw_pkg::ADDR_DATA_HIGH: x = len * 4 + (shadow >> 4);
      default: x = 0;
    endcase
    chk("rdata", x, r);
    chk("rd_err", a > 8'h18 || a[1:0] != 0, e);
  endtask
  task automatic rdcount;
    rd(cpw_pkg::ADDR_DATA_LOW);
    rd(cpw_pkg::ADDR_DATA_MID);
    rd(cpw_pkg::ADDR_DATA_HIGH);
    chk("cmp_irqs", mcmp, ncmp);
    chk("roll_irqs", mroll, nroll);
  endtask
  task automatic setv(input int v, input int l);
    wr(cpw_pkg::ADDR_DATA_LOW, v & 15);
    wr(cpw_pkg::ADDR_DATA_MID, (v >> 4) & 15);
    wr(cpw_pkg::ADDR_DATA_HIGH, l * 4 + (v >> 8));
  endtask
  task automatic step;
    count_clk_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    mstep;
    count_clk_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk("pin", route ? pwm : 0, pwm_output_pin_o);
  endtask
  task automatic run(input int u, l, f, rt, s, c, n);
    wr(cpw_pkg::ADDR_CTRL_TWO, 0);
    wr(cpw_pkg::ADDR_CTRL_ONE, u * 8 + 1);
    setv(s, l);
    wr(cpw_pkg::ADDR_CTRL_TWO, 1);
    wr(cpw_pkg::ADDR_PRESC, rt * 8);
    wr(cpw_pkg::ADDR_SYS_ONE, f * 2);
    setv(c, l);
    // Clock held high so the start sees a falling edge first
    count_clk_i <= 1'b1;
    wr(cpw_pkg::ADDR_CTRL_TWO, 10);
    count_clk_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    repeat (n) step;
    rdcount;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int v;
    int u;
    int s;
    {up, sel, start, ev, cmpen, full, route, len, preset, count, shadow} = '0;
    {mcmp, mroll} = '0;
    pwm = 1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    for (int a = 0; a <= 32'h20; a += 4) rd(a[7:0]);
    wr(8'h1C, 32'hF);
    wr(8'h21, 32'hF);
    repeat (8) begin
      v = $random(seed) & 1023;
      u = $random(seed) & 1;
      s = $random(seed) & 7;
      wr(cpw_pkg::ADDR_CTRL_TWO, 4);
      chk("evcnt", 1, event_count_enable_o);
      wr(cpw_pkg::ADDR_CTRL_ONE, u * 8 + s);
      chk("clksel", s, clock_select_o);
      setv(v, s & 3);
      wr(cpw_pkg::ADDR_CTRL_TWO, 3);
      rd(cpw_pkg::ADDR_CTRL_TWO);
      rdcount;
      wr(cpw_pkg::ADDR_CTRL_ONE, (1 - u) * 8 + s);
      rdcount;
    end
    run(1, 3, 1, 1, 0, 32'h052, 90);
    run(0, 3, 0, 1, 32'h3A5, 32'h0A7, 40);
    run(1, 0, 1, 0, 32'h3F0, 32'h3F8, 24);
    run(0, 1, 1, 1, 32'h010, 32'h3FA, 30);
    run(0, 3, 1, 1, 32'h3FF, 32'h3A7, 96);
    run(1, 2, 0, 1, 32'h030, 32'h005, 70);
    wr(cpw_pkg::ADDR_CTRL_TWO, 0);
    setv(0, 0);
    count_clk_i <= 1'b1;
    wr(cpw_pkg::ADDR_CTRL_TWO, 8);
    count_clk_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    step;
    wr(cpw_pkg::ADDR_CTRL_TWO, 9);
    rd(cpw_pkg::ADDR_CTRL_TWO);
    step;
    rdcount;
    wrap_up;
  end
endmodule // tb
